// [hw/pci_tmo_defs.svh]
// Purpose: Offsets, field positions and reset values of the timeout block
// Assumes: 32-bit AXI4-Lite data, byte addresses
// Notes: Definitions only
`ifndef PCI_TMO_DEFS_SVH
`define PCI_TMO_DEFS_SVH
// Register byte addresses
`define TMO_ADDR_W 8
`define TMO_CTRL_OFF 8'h00
`define TMO_STS_OFF 8'h04
`define TMO_MASK_OFF 8'h08
`define TMO_CNT_OFF 8'h0c
`define TMO_BC1_OFF 8'h40
// Control fields
`define TMO_TIMER_W 5
`define TMO_TIMER_LSB 0
`define TMO_EN_BIT 5
`define TMO_CTRL_RST 5'h00
// Counter geometry: timer is the top five of eight bits
`define TMO_CNT_W 8
`define TMO_LOW_W 3
// Status and mask bits
`define TMO_STS_W 2
`define TMO_STS_NOTRDY 0
`define TMO_STS_RETRY 1
`define TMO_STS_RST 2'h0
`define TMO_MASK_RST 2'h0
// Bus control one register
`define TMO_BC1_W 8
`define TMO_BC1_RST 8'h00
// AXI responses
`define TMO_RESP_OKAY 2'h0
`define TMO_RESP_SLVERR 2'h2
`endif

// [hw/pci_tmo_pkg.sv]
// Purpose: Types shared by the timeout block
// Assumes: Nothing beyond the defs header
// Notes: Watchdog states are Gray coded along idle-wait-abort-drain
package pci_tmo_pkg;
  // Watchdog state
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_WAIT = 2'h1,
    ST_ABORT = 2'h3,
    ST_DRAIN = 2'h2
  } wd_state_e;
endpackage : pci_tmo_pkg

// [hw/pci_master_target_timeout.sv]
// Purpose: Target response watchdog for the host PCI bus master
// Assumes: PCI clock equals aclk; master status inputs are on aclk
// Notes: Registers over AXI4-Lite; one level interrupt
//
// Our own choice: the AXI4-Lite interface to the registers.
`include "pci_tmo_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module pci_master_target_timeout (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic awvalid,
  output logic awready,
  input wire logic [`TMO_ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  // AXI4-Lite write data
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // AXI4-Lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // AXI4-Lite read address
  input wire logic arvalid,
  output logic arready,
  input wire logic [`TMO_ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  // AXI4-Lite read data
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // Bus master status, same clock
  input wire logic mst_active,
  input wire logic data_done,
  input wire logic target_retry,
  // Outcome toward the master and system
  output logic master_abort,
  output logic serr_n,
  output logic irq
);
  // Register state
  logic [`TMO_TIMER_W-1:0] timer_reg; // Programmed timeout
  logic enable_reg; // Watchdog on
  logic [`TMO_STS_W-1:0] sts_reg; // Sticky events
  logic [`TMO_STS_W-1:0] mask_reg; // Interrupt enables
  logic [`TMO_BC1_W-1:0] bc1_reg; // Bus control one, stored only
  // Watchdog state
  pci_tmo_pkg::wd_state_e state_reg;
  pci_tmo_pkg::wd_state_e state_next;
  logic [`TMO_CNT_W-1:0] cnt_reg; // Timeout counter
  logic retried_reg; // Retry seen since last good transfer
  logic expire; // Counter ran out this cycle
  logic [`TMO_STS_W-1:0] sts_set; // Events this cycle
  // Write channel capture
  logic aw_held_reg;
  logic w_held_reg;
  logic [`TMO_ADDR_W-1:0] waddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic do_write;
  logic do_read;
  logic sts_rd_clr; // Read of status clears it

  // Starting value: timer in the top bits, low bits implied zero
  function automatic logic [`TMO_CNT_W-1:0] load_val(
    input logic [`TMO_TIMER_W-1:0] t);
    load_val = {t, {`TMO_LOW_W{1'b0}}};
  endfunction : load_val

  // Address is one of the mapped words
  function automatic logic mapped(input logic [`TMO_ADDR_W-1:0] a);
    mapped = (a == `TMO_CTRL_OFF) || (a == `TMO_STS_OFF) ||
      (a == `TMO_MASK_OFF) || (a == `TMO_CNT_OFF) ||
      (a == `TMO_BC1_OFF);
  endfunction : mapped

  assign do_write = aw_held_reg && w_held_reg && !bvalid;
  assign do_read = arvalid && arready;
  assign sts_rd_clr = do_read && (araddr == `TMO_STS_OFF);
  assign expire = (state_reg == pci_tmo_pkg::ST_WAIT) && mst_active &&
    !data_done && (cnt_reg == {`TMO_CNT_W{1'b0}});

  // Watchdog next state
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      pci_tmo_pkg::ST_IDLE: begin
        // Arm only when software has enabled the timer
        if (mst_active && enable_reg) begin
          state_next = pci_tmo_pkg::ST_WAIT;
        end
      end
      pci_tmo_pkg::ST_WAIT: begin
        if (!mst_active || !enable_reg) begin
          state_next = pci_tmo_pkg::ST_IDLE;
        end else if (expire) begin
          state_next = pci_tmo_pkg::ST_ABORT;
        end
      end
      pci_tmo_pkg::ST_ABORT: begin
        state_next = pci_tmo_pkg::ST_DRAIN;
      end
      pci_tmo_pkg::ST_DRAIN: begin
        // Wait for the master to drop the cycle before rearming
        if (!mst_active) begin
          state_next = pci_tmo_pkg::ST_IDLE;
        end
      end
      default: begin
        state_next = pci_tmo_pkg::ST_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= pci_tmo_pkg::ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Timeout counter
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_reg <= {`TMO_CNT_W{1'b0}};
    end else if (state_reg != pci_tmo_pkg::ST_WAIT) begin
      cnt_reg <= load_val(timer_reg);
    end else if (data_done) begin
      cnt_reg <= load_val(timer_reg);
    end else if (cnt_reg != {`TMO_CNT_W{1'b0}}) begin
      // Retries do not reload, so a retrying target still times out
      cnt_reg <= cnt_reg - 8'h01;
    end
  end

  // Remember retries since the last good data transfer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      retried_reg <= 1'b0;
    end else if (state_reg != pci_tmo_pkg::ST_WAIT || data_done) begin
      retried_reg <= 1'b0;
    end else if (target_retry) begin
      retried_reg <= 1'b1;
    end
  end

  // Abort and system error, one cycle each
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      master_abort <= 1'b0;
      serr_n <= 1'b1;
    end else begin
      master_abort <= expire;
      serr_n <= !expire;
    end
  end

  // Events by cause
  assign sts_set[`TMO_STS_NOTRDY] = expire && !retried_reg;
  assign sts_set[`TMO_STS_RETRY] = expire && retried_reg;

  // Sticky status; a new event wins over the read clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sts_reg <= `TMO_STS_RST;
    end else if (sts_rd_clr) begin
      sts_reg <= sts_set;
    end else begin
      sts_reg <= sts_reg | sts_set;
    end
  end

  // Interrupt level
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(sts_reg & mask_reg);
    end
  end

  // Write address and data are taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      waddr_reg <= {`TMO_ADDR_W{1'b0}};
      awready <= 1'b0;
    end else begin
      awready <= !aw_held_reg && !awready;
      if (awvalid && awready) begin
        aw_held_reg <= 1'b1;
        waddr_reg <= awaddr;
        awready <= 1'b0;
      end else if (do_write) begin
        aw_held_reg <= 1'b0;
      end
    end
  end

  // Write data capture
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_reg <= 1'b0;
      wdata_reg <= 32'h0;
      wstrb_reg <= 4'h0;
      wready <= 1'b0;
    end else begin
      wready <= !w_held_reg && !wready;
      if (wvalid && wready) begin
        w_held_reg <= 1'b1;
        wdata_reg <= wdata;
        wstrb_reg <= wstrb;
        wready <= 1'b0;
      end else if (do_write) begin
        w_held_reg <= 1'b0;
      end
    end
  end

  // Write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp <= `TMO_RESP_OKAY;
    end else if (do_write) begin
      bvalid <= 1'b1;
      // Unmapped addresses answer with a slave error
      bresp <= mapped(waddr_reg) ? `TMO_RESP_OKAY : `TMO_RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // Software writable registers; all fields sit in byte lane 0
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timer_reg <= `TMO_CTRL_RST;
      enable_reg <= 1'b0;
      mask_reg <= `TMO_MASK_RST;
      bc1_reg <= `TMO_BC1_RST;
    end else if (do_write && wstrb_reg[0]) begin
      case (waddr_reg)
        `TMO_CTRL_OFF: begin
          timer_reg <= wdata_reg[`TMO_TIMER_LSB+:`TMO_TIMER_W];
          enable_reg <= wdata_reg[`TMO_EN_BIT];
        end
        `TMO_MASK_OFF: begin
          mask_reg <= wdata_reg[`TMO_STS_W-1:0];
        end
        `TMO_BC1_OFF: begin
          bc1_reg <= wdata_reg[`TMO_BC1_W-1:0];
        end
        default: begin
          // Read-only or unmapped: nothing stored
        end
      endcase
    end
  end

  // Read address accepted only while no answer is pending
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
    end else begin
      arready <= !rvalid && !arready && !do_read;
    end
  end

  // Read data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata <= 32'h0;
      rresp <= `TMO_RESP_OKAY;
    end else if (do_read) begin
      rvalid <= 1'b1;
      rresp <= mapped(araddr) ? `TMO_RESP_OKAY : `TMO_RESP_SLVERR;
      case (araddr)
        `TMO_CTRL_OFF: rdata <= {26'h0, enable_reg, timer_reg};
        `TMO_STS_OFF: rdata <= {30'h0, sts_reg};
        `TMO_MASK_OFF: rdata <= {30'h0, mask_reg};
        `TMO_CNT_OFF: rdata <= {24'h0, cnt_reg};
        `TMO_BC1_OFF: rdata <= {24'h0, bc1_reg};
        default: rdata <= 32'h0;
      endcase
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  // Checks
  property p_load;
    @(posedge aclk) disable iff (!aresetn)
    (state_reg == pci_tmo_pkg::ST_IDLE) ##1
    (state_reg == pci_tmo_pkg::ST_WAIT) |->
    cnt_reg == {$past(timer_reg), 3'h0};
  endproperty
  a_load: assert property (p_load)
    else $error("counter not loaded from timer");

  property p_reload;
    @(posedge aclk) disable iff (!aresetn)
    (state_reg == pci_tmo_pkg::ST_WAIT) && mst_active && enable_reg &&
    data_done |=> cnt_reg == {timer_reg, 3'h0};
  endproperty
  a_reload: assert property (p_reload)
    else $error("counter not reloaded on data transfer");

  property p_abort;
    @(posedge aclk) disable iff (!aresetn)
    (state_reg == pci_tmo_pkg::ST_WAIT) && mst_active && !data_done &&
    cnt_reg == 8'h00 |=> master_abort ##1 !master_abort;
  endproperty
  a_abort: assert property (p_abort)
    else $error("missing single master abort on expiry");

  property p_serr;
    @(posedge aclk) disable iff (!aresetn)
    master_abort |-> !serr_n && state_reg == pci_tmo_pkg::ST_ABORT;
  endproperty
  a_serr: assert property (p_serr)
    else $error("abort without system error");

  property p_retry_count;
    @(posedge aclk) disable iff (!aresetn)
    (state_reg == pci_tmo_pkg::ST_WAIT) && target_retry && !data_done &&
    cnt_reg != 8'h00 |=> cnt_reg != {timer_reg, 3'h0} ||
    $past(cnt_reg) == 8'h01;
  endproperty
  a_retry_count: assert property (p_retry_count)
    else $error("retry reloaded the counter");

  property p_retry_abort;
    @(posedge aclk) disable iff (!aresetn)
    expire && retried_reg |=> master_abort && !serr_n ##1
    sts_reg[`TMO_STS_RETRY];
  endproperty
  a_retry_abort: assert property (p_retry_abort)
    else $error("retry timeout not aborted");

  property p_step;
    @(posedge aclk) disable iff (!aresetn)
    (state_reg == pci_tmo_pkg::ST_WAIT) && !data_done &&
    cnt_reg != 8'h00 |=> cnt_reg == $past(cnt_reg) - 8'h01;
  endproperty
  a_step: assert property (p_step)
    else $error("counter did not step by one");
endmodule : pci_master_target_timeout
`default_nettype wire

// [bench/pci_target_model.sv]
// Purpose: Behavioural PCI target facing the host master watchdog
// Assumes: Same clock as the watchdog; answers only while the master is busy
// Notes: Mode 0 silent, 1 completes data phases, 2 keeps retrying
`timescale 1ns/1ps
`default_nettype none
module pci_target_model (
  // Clock
  input wire logic aclk,
  // Master state and answer style chosen by the bench
  input wire logic mst_active,
  input wire logic [1:0] mode,
  input wire logic [3:0] gap,
  // Answers toward the master
  output logic data_done,
  output logic target_retry
);
  // Cycles since the last answer
  logic [3:0] wait_reg;
  initial begin
    data_done = 1'b0;
    target_retry = 1'b0;
    wait_reg = 4'h0;
  end
  // One answer pulse every gap+1 cycles; silence when idle or in mode 0
  always @(posedge aclk) begin
    if (mst_active && mode != 2'h0 && wait_reg == gap) begin
      wait_reg <= 4'h0;
      data_done <= (mode == 2'h1);
      target_retry <= (mode == 2'h2);
    end else begin
      // Count only while busy so each phase starts its wait afresh
      wait_reg <= mst_active ? wait_reg + 4'h1 : 4'h0;
      data_done <= 1'b0;
      target_retry <= 1'b0;
    end
  end
endmodule : pci_target_model
`default_nettype wire

// [bench/test_pci_master_target_timeout.sv]
// Purpose: Self-checking bench for the target response watchdog
// Assumes: Bench is the AXI4-Lite master and drives mst_active
// Notes: Abort delay is measured in cycles from mst_active rising
`include "pci_tmo_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module test_pci_master_target_timeout;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, mst_active;
  logic data_done, target_retry, master_abort, serr_n, irq;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp, mode;
  logic [3:0] gap;
  int err_count, total_checks, cycles;
  logic [7:0] rst_addr [5] = '{`TMO_CTRL_OFF, `TMO_STS_OFF, `TMO_MASK_OFF,
    `TMO_CNT_OFF, `TMO_BC1_OFF};
  pci_master_target_timeout u_pci_master_target_timeout (.aclk(aclk),
    .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
    .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid), .wready(wready),
    .wdata(wdata), .wstrb(4'hf), .bvalid(bvalid), .bready(bready),
    .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .arprot(3'h0), .rvalid(rvalid), .rready(rready), .rdata(rdata),
    .rresp(rresp), .mst_active(mst_active), .data_done(data_done),
    .target_retry(target_retry), .master_abort(master_abort),
    .serr_n(serr_n), .irq(irq));
  pci_target_model u_pci_target_model (.aclk(aclk), .mst_active(mst_active),
    .mode(mode), .gap(gap), .data_done(data_done),
    .target_retry(target_retry));
  // 125 MHz clock
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  // Hang guard, far above the few hundred cycles the tests need
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_count++;
      close_out();
    end
  end
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : close_out
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string m);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk
  // Write; ready is looked at before the edge that takes the item
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    logic ta, tw;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(negedge aclk);
      if (bvalid === 1'b1) break;
      ta = awvalid & (awready === 1'b1);
      tw = wvalid & (wready === 1'b1);
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end
    chk(bresp, er, "write response");
    @(posedge aclk);
    bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] ed,
                    input logic [1:0] er);
    logic ta;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(negedge aclk);
      if (rvalid === 1'b1) break;
      ta = arvalid & (arready === 1'b1);
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
    end
    chk(rresp, er, "read response");
    chk(rdata, ed, "read data");
    @(posedge aclk);
    rready <= 1'b0;
  endtask : rd
  // Raise the master, time the abort and its one-cycle pulses
  task automatic trip(input int exp_n, input logic exp_irq);
    int n;
    @(posedge aclk);
    mst_active <= 1'b1;
    n = 0;
    do begin
      @(negedge aclk);
      n++;
    end while (master_abort !== 1'b1 && n < 400);
    chk(n, exp_n, "abort delay");
    chk(serr_n, 1'b0, "serr low with abort");
    @(negedge aclk);
    chk(master_abort, 1'b0, "abort pulse length");
    chk(serr_n, 1'b1, "serr pulse length");
    chk(irq, exp_irq, "irq after abort");
    @(posedge aclk);
    mst_active <= 1'b0;
    repeat (2) @(posedge aclk);
  endtask : trip
  // Master busy for a while with no abort expected
  task automatic quiet(input int cyc);
    int hits;
    hits = 0;
    @(posedge aclk);
    mst_active <= 1'b1;
    repeat (cyc) begin
      @(negedge aclk);
      if (master_abort !== 1'b0) hits++;
    end
    chk(hits, 0, "unexpected abort");
    @(posedge aclk);
    mst_active <= 1'b0;
    repeat (2) @(posedge aclk);
  endtask : quiet
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, mst_active} = 7'h0;
    {awaddr, araddr, wdata, mode, gap, err_count, total_checks} = '0;
    cycles = 0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    chk({serr_n, master_abort, irq}, 3'h4, "outputs after reset");
    foreach (rst_addr[i]) rd(rst_addr[i], 32'h0, `TMO_RESP_OKAY);
    rd(8'h10, 32'h0, `TMO_RESP_SLVERR);
    wr(8'h10, 32'hff, `TMO_RESP_SLVERR);
    wr(`TMO_BC1_OFF, 32'ha5, `TMO_RESP_OKAY);
    rd(`TMO_BC1_OFF, 32'ha5, `TMO_RESP_OKAY);
    $display("test registers done");
    wr(`TMO_MASK_OFF, 32'h3, `TMO_RESP_OKAY);
    for (int t = 1; t <= 3; t += 2) begin
      wr(`TMO_CTRL_OFF, 32'h20 | t, `TMO_RESP_OKAY);
      trip(8 * t + 3, 1'b1);
      rd(`TMO_STS_OFF, 32'h1, `TMO_RESP_OKAY);
      rd(`TMO_STS_OFF, 32'h0, `TMO_RESP_OKAY);
      repeat (2) @(negedge aclk);
      chk(irq, 1'b0, "irq after clear");
    end
    $display("test no target ready done");
    wr(`TMO_CTRL_OFF, 32'h21, `TMO_RESP_OKAY);
    mode <= 2'h1;
    gap <= 4'h5;
    quiet(80);
    rd(`TMO_STS_OFF, 32'h0, `TMO_RESP_OKAY);
    $display("test reload done");
    wr(`TMO_MASK_OFF, 32'h1, `TMO_RESP_OKAY);
    mode <= 2'h2;
    gap <= 4'h2;
    trip(11, 1'b0);
    rd(`TMO_STS_OFF, 32'h2, `TMO_RESP_OKAY);
    $display("test endless retry done");
    mode <= 2'h0;
    wr(`TMO_CTRL_OFF, 32'h01, `TMO_RESP_OKAY);
    quiet(40);
    $display("test disabled done");
    close_out();
  end
endmodule : test_pci_master_target_timeout
`default_nettype wire
